// ### logic/ftmc_map.svh
`ifndef FTMC_MAP_SVH
`define FTMC_MAP_SVH
// ======================================================
// timebase
`define FTMC_CLK_KHZ 64'd20000
`define FTMC_EN_LOW_MS 64'd1000
`define FTMC_RETRY_MS 64'd100
`define FTMC_FLASH_STEP_US 64'd156250
`define FTMC_US_PER_MS 64'd1000
// ======================================================
// serial map
`define FTMC_DEV_ADDR 7'h5A
`define FTMC_REG_MASTER 3'h0
`define FTMC_REG_FLASH 3'h1
`define FTMC_REG_TORCH 3'h2
`define FTMC_RUN_BIT 3
`define FTMC_FLASH_RST 8'hE0
`define FTMC_TORCH_RST 8'h00
`define FTMC_TORCH_WMASK 8'h3F
`endif

// ### logic/ftmc_pkg.sv
package ftmc_pkg;
   typedef enum logic [2:0] {
      F_RUN = 3'b001,
      F_RETRY = 3'b010,
      F_OVP = 3'b100
   } ftmc_fault_t;
   typedef enum logic [8:0] {
      L_IDLE = 9'h001,
      L_DEV = 9'h002,
      L_DEV_ACK = 9'h004,
      L_REG = 9'h008,
      L_REG_ACK = 9'h010,
      L_WR = 9'h020,
      L_WR_ACK = 9'h040,
      L_RD = 9'h080,
      L_RD_ACK = 9'h100
   } ftmc_link_st_t;
   typedef struct packed {
      logic [2:0] timeout;
      logic en;
      logic [3:0] level;
   } ftmc_flash_reg_t;
   typedef struct packed {
      logic [1:0] spare;
      logic inhibit;
      logic en;
      logic [3:0] level;
   } ftmc_torch_reg_t;
   typedef struct packed {
      logic en;
      logic torch;
      logic flash;
      logic inhibit;
      logic overvoltage_guard;
      logic open_l;
      logic short_l;
      logic therm;
   } ftmc_pins_t;
   typedef struct packed {
      ftmc_pins_t sync1;
      ftmc_pins_t sync2;
      logic tog1;
      logic tog2;
      logic tog3;
      logic run;
      ftmc_flash_reg_t freg;
      ftmc_torch_reg_t treg;
      logic pin_alive;
      logic [31:0] low_cnt;
      logic pin_prev;
      logic reg_prev;
      logic [31:0] tmr;
      logic timed_out;
      ftmc_fault_t fault;
      logic [31:0] retry_cnt;
      logic short_flag;
      logic open_flag;
      logic standby;
      logic boost;
      logic flash_on;
      logic torch_on;
      logic range_flash;
      logic [3:0] level;
   } ftmc_core_t;
   typedef struct packed {
      ftmc_link_st_t state;
      logic [2:0] cnt;
      logic [7:0] shift;
      logic rw;
      logic [2:0] ptr;
      logic run;
      ftmc_flash_reg_t freg;
      ftmc_torch_reg_t treg;
      logic wr_tog;
      logic start_seen;
      logic [2:0] st1;
      logic [2:0] st2;
      logic [7:0] rdata;
   } ftmc_link_t;
endpackage

// ### logic/ftmc_top.sv
// Behaviour
// - chip enable pin high puts the device in standby (enabled)
// - shutdown only after enable pin stays low over one second
// - a register run bit enables the device like the pin
// - torch mode runs while the torch request pin is high
// - flash trigger rising edge starts flash and its safety timer
// - inhibit high in flash drops both channels to torch level
// - flash from pin or register, stops when both off, timeout applies
// - flash level is max flash current times selected step
// - flash current cut once enabled longer than programmed timeout
// - inhibit works the same for pin or register flash
// - torch from pin or register, stops when both are off
// - torch level is max torch current times selected step
// - overvoltage guard turns the device off; the code latches boost and regulators off until disabled, STANDBY stays high
// - both lamps open while regulating: off, retry after 100 ms
// - lamp short while regulating: off, retry 100 ms, repeat
// - master drives the bus, device drives only acknowledges and read data bits
// - read is address write, repeated start, read, then data
// - device answers slave address 1011010, B4 write, B5 read
// - register address byte decoded on its low three bits only
// - reg 00h: run bit D3, short D2, open D1, thermal D0
// - reg 01h: timeout 7:5, flash enable 4, level 3:0
// - timeout is (code+1) times 156.25 ms, default code 111
// - reg 02h: torch level, torch enable and inhibit bits
`include "ftmc_map.svh"

module ftmc_top
   import ftmc_pkg::*;
#(
   parameter int unsigned SHUT_CYC =
      int'(`FTMC_EN_LOW_MS * `FTMC_CLK_KHZ),
   parameter int unsigned RETRY_CYC =
      int'(`FTMC_RETRY_MS * `FTMC_CLK_KHZ),
   parameter int unsigned STEP_CYC =
      int'(`FTMC_FLASH_STEP_US * `FTMC_CLK_KHZ / `FTMC_US_PER_MS)
) (
   input wire logic CORE_CLK, // core clock
   input wire logic RST, // async reset, high
   input wire logic SCL, // serial bus clock
   input wire logic SDA_IN, // serial data level
   output logic SDA_OUT, // serial data drive value
   output logic SDA_OE_N, // low while pulling data low
   input wire logic CHIP_EN_PIN, // chip enable pin
   input wire logic TORCH_REQUEST_PIN, // torch request pin
   input wire logic FLASH_TRIGGER_PIN, // flash trigger pin
   input wire logic FLASH_INHIBIT_PIN, // flash inhibit pin
   input wire logic OVERVOLTAGE_GUARD, // output over threshold
   input wire logic OPEN_LAMP_DETECTOR, // both lamps open
   input wire logic LAMP_SHORT_DETECT, // a lamp shorted
   input wire logic THERMAL_TRIP, // die too hot
   output logic STANDBY, // device enabled
   output logic BOOST_EN, // boost and current regulators on
   output logic FLASH_ON, // flash mode active
   output logic TORCH_ON, // torch mode active
   output logic LEVEL_RANGE_FLASH, // 1 flash max, 0 torch max
   output logic [3:0] LEVEL_CODE // percentage step code
);
   // ======================================================
   // core domain
   ftmc_core_t c;
   ftmc_core_t next_c;
   ftmc_link_t l;
   logic active;
   logic flash_req;
   logic torch_req;
   logic inhib;
   logic flash_restart;
   logic go;
   logic [31:0] flash_limit;

   always_comb begin
      next_c = c;
      next_c.sync1 = '{en: CHIP_EN_PIN, torch: TORCH_REQUEST_PIN,
         flash: FLASH_TRIGGER_PIN, inhibit: FLASH_INHIBIT_PIN,
         overvoltage_guard: OVERVOLTAGE_GUARD, open_l: OPEN_LAMP_DETECTOR,
         short_l: LAMP_SHORT_DETECT, therm: THERMAL_TRIP};
      next_c.sync2 = c.sync1;
      // register copy: link fields are stable long after the toggle
      next_c.tog1 = l.wr_tog;
      next_c.tog2 = c.tog1;
      next_c.tog3 = c.tog2;
      if (c.tog2 != c.tog3) begin
         next_c.run = l.run;
         next_c.freg = l.freg;
         next_c.treg = l.treg;
      end
      if (c.sync2.en) begin
         next_c.pin_alive = 1'b1;
         next_c.low_cnt = 32'h0;
      end else if (c.low_cnt == SHUT_CYC) begin
         next_c.pin_alive = 1'b0;
      end else begin
         next_c.low_cnt = c.low_cnt + 32'h1;
      end
      active = c.pin_alive | c.run;
      flash_req = c.sync2.flash | c.freg.en;
      torch_req = c.sync2.torch | c.treg.en;
      inhib = c.sync2.inhibit | c.treg.inhibit;
      // restart on a pin edge or a fresh register enable
      flash_restart = (c.sync2.flash & ~c.pin_prev) |
         (c.freg.en & ~c.reg_prev);
      next_c.pin_prev = c.sync2.flash;
      next_c.reg_prev = c.freg.en;
      flash_limit = (32'(c.freg.timeout) + 32'h1) * STEP_CYC;
      if (flash_restart) begin
         next_c.tmr = 32'h0;
         next_c.timed_out = 1'b0;
      end else if (!flash_req) begin
         next_c.tmr = 32'h0;
         next_c.timed_out = 1'b0;
      end else if (c.flash_on) begin
         if (c.tmr >= flash_limit - 32'h1) begin
            next_c.timed_out = 1'b1;
         end else begin
            next_c.tmr = c.tmr + 32'h1;
         end
      end
      // ----- faults
      case (c.fault)
         F_RUN: begin
            if (c.sync2.overvoltage_guard) begin
               next_c.fault = F_OVP;
            end else if (c.boost && c.sync2.short_l) begin
               next_c.fault = F_RETRY;
               next_c.retry_cnt = 32'h0;
            end else if (c.boost && c.sync2.open_l) begin
               next_c.fault = F_RETRY;
               next_c.retry_cnt = 32'h0;
            end
         end
         F_RETRY: begin
            if (c.sync2.overvoltage_guard) begin
               next_c.fault = F_OVP;
            end else if (c.retry_cnt == RETRY_CYC - 1) begin
               next_c.fault = F_RUN;
            end else begin
               next_c.retry_cnt = c.retry_cnt + 32'h1;
            end
         end
         F_OVP: next_c.fault = F_OVP;
         default: next_c.fault = F_RUN;
      endcase
      // a short or open is only judged while regulating; flags sticky
      if (c.boost && c.sync2.short_l) begin
         next_c.short_flag = 1'b1;
      end else if (!active) begin
         next_c.short_flag = 1'b0;
      end
      if (c.boost && c.sync2.open_l) begin
         next_c.open_flag = 1'b1;
      end else if (!active) begin
         next_c.open_flag = 1'b0;
      end
      // power-off clears a latched overvoltage trip
      if (!active) begin
         next_c.fault = F_RUN;
         next_c.retry_cnt = 32'h0;
      end
      go = active & (c.fault == F_RUN) & ~c.sync2.therm;
      next_c.standby = active;
      next_c.flash_on = go & flash_req & ~next_c.timed_out;
      next_c.torch_on = go & torch_req & ~next_c.flash_on;
      next_c.boost = next_c.flash_on | next_c.torch_on;
      next_c.range_flash = next_c.flash_on & ~inhib;
      next_c.level = next_c.range_flash ? c.freg.level :
         c.treg.level;
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         c <= '0;
         c.fault <= F_RUN;
         c.freg <= `FTMC_FLASH_RST;
         c.treg <= `FTMC_TORCH_RST;
      end else begin
         c <= next_c;
      end
   end

   assign STANDBY = c.standby;
   assign BOOST_EN = c.boost;
   assign FLASH_ON = c.flash_on;
   assign TORCH_ON = c.torch_on;
   assign LEVEL_RANGE_FLASH = c.range_flash;
   assign LEVEL_CODE = c.level;

   // ======================================================
   // serial link domain
   ftmc_link_t next_l;
   logic start_tog;
   logic oe_n;
   logic sda_drv;
   logic [7:0] byte_in;
   logic [7:0] rd_mux;

   // start: data falls while the bus clock is high
   always_ff @(negedge SDA_IN or posedge RST) begin
      if (RST) begin
         start_tog <= 1'b0;
      end else if (SCL) begin
         start_tog <= ~start_tog;
      end
   end

   always_comb begin
      next_l = l;
      byte_in = {l.shift[6:0], SDA_IN};
      case (l.ptr)
         `FTMC_REG_MASTER: rd_mux = {4'h0, l.run, l.st2};
         `FTMC_REG_FLASH: rd_mux = l.freg;
         `FTMC_REG_TORCH: rd_mux = l.treg;
         default: rd_mux = 8'h00;
      endcase
      next_l.st1 = {c.short_flag, c.open_flag, c.sync2.therm};
      next_l.st2 = l.st1;
      if (start_tog != l.start_seen) begin
         next_l.start_seen = start_tog;
         next_l.state = L_DEV;
         next_l.shift = {7'h00, SDA_IN};
         next_l.cnt = 3'h1;
      end else begin
         case (l.state)
            L_DEV, L_REG, L_WR: begin
               next_l.shift = byte_in;
               next_l.cnt = l.cnt + 3'h1;
               if (l.cnt == 3'h7) begin
                  case (l.state)
                     L_DEV: begin
                        next_l.rw = byte_in[0];
                        next_l.state = (byte_in[7:1] == `FTMC_DEV_ADDR) ?
                           L_DEV_ACK : L_IDLE;
                     end
                     L_REG: begin
                        next_l.ptr = byte_in[2:0];
                        next_l.state = L_REG_ACK;
                     end
                     default: begin
                        next_l.state = L_WR_ACK;
                        next_l.wr_tog = ~l.wr_tog;
                        case (l.ptr)
                           `FTMC_REG_MASTER:
                              next_l.run = byte_in[`FTMC_RUN_BIT];
                           `FTMC_REG_FLASH: next_l.freg = byte_in;
                           `FTMC_REG_TORCH:
                              next_l.treg = byte_in & `FTMC_TORCH_WMASK;
                           default: next_l.run = l.run;
                        endcase
                     end
                  endcase
               end
            end
            L_DEV_ACK: begin
               next_l.cnt = 3'h0;
               next_l.state = l.rw ? L_RD : L_REG;
               next_l.rdata = rd_mux;
            end
            L_REG_ACK, L_WR_ACK: begin
               next_l.cnt = 3'h0;
               next_l.state = L_WR;
            end
            L_RD: begin
               next_l.cnt = l.cnt + 3'h1;
               if (l.cnt == 3'h7) begin
                  next_l.state = L_RD_ACK;
               end
            end
            L_RD_ACK: begin
               next_l.cnt = 3'h0;
               next_l.rdata = rd_mux;
               next_l.state = SDA_IN ? L_IDLE : L_RD;
            end
            L_IDLE: next_l.state = L_IDLE;
            default: next_l.state = L_IDLE;
         endcase
      end
   end

   always_ff @(posedge SCL or posedge RST) begin
      if (RST) begin
         l <= '0;
         l.state <= L_IDLE;
         l.freg <= `FTMC_FLASH_RST;
         l.treg <= `FTMC_TORCH_RST;
      end else begin
         l <= next_l;
      end
   end

   // drive changes on the falling edge so data is stable at rise
   always_ff @(negedge SCL or posedge RST) begin
      if (RST) begin
         oe_n <= 1'b1;
         sda_drv <= 1'b0;
      end else begin
         sda_drv <= 1'b0;
         oe_n <= ~((l.state == L_DEV_ACK) || (l.state == L_REG_ACK) ||
            (l.state == L_WR_ACK) ||
            ((l.state == L_RD) && !l.rdata[~l.cnt]));
      end
   end

   assign SDA_OE_N = oe_n;
   assign SDA_OUT = sda_drv;

   // ======================================================
   // checks
   chk_en_standby: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      c.sync2.en |=> ##1 STANDBY)
      else $error("enable pin did not enable");
   chk_shutdown_hold: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      $fell(c.pin_alive) |-> $past(c.low_cnt) == SHUT_CYC)
      else $error("shutdown before low time elapsed");
   chk_run_bit: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      c.run |=> STANDBY)
      else $error("run bit did not enable");
   chk_torch_on: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (go && torch_req && !flash_req) |=> TORCH_ON)
      else $error("torch not started");
   chk_flash_restart: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      $rose(c.sync2.flash) |=> c.tmr == 32'h0 && !c.timed_out)
      else $error("flash timer not restarted");
   chk_inhibit_level: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      (FLASH_ON && !LEVEL_RANGE_FLASH) |->
         $past(inhib) && LEVEL_CODE == $past(c.treg.level))
      else $error("inhibit level wrong");
   chk_mode_excl: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      !(FLASH_ON && TORCH_ON))
      else $error("flash and torch active together");
   chk_flash_timeout: assert property (@(posedge CORE_CLK)
      disable iff (RST)
      (c.timed_out && !flash_restart) |=> !FLASH_ON)
      else $error("flash ran past timeout");
   chk_ovp_off: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (c.sync2.overvoltage_guard && active) |-> ##2 !BOOST_EN)
      else $error("overvoltage did not turn off");
   chk_open_retry: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (c.fault == F_RUN && c.boost && c.sync2.open_l && !c.sync2.overvoltage_guard
         && active) |=> c.fault == F_RETRY ##1 !BOOST_EN)
      else $error("open lamps did not force retry");
   chk_retry_off: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (c.fault == F_RUN && c.boost && c.sync2.short_l && !c.sync2.overvoltage_guard
         && active) |=> c.fault == F_RETRY ##1 !BOOST_EN)
      else $error("short did not force retry");
   chk_ack_only: assert property (@(posedge SCL) disable iff (RST)
      !SDA_OE_N |-> (l.state inside {L_DEV_ACK, L_REG_ACK, L_WR_ACK,
         L_RD}))
      else $error("data driven outside ack or read");
   chk_addr_match: assert property (@(posedge SCL) disable iff (RST)
      (l.state == L_DEV_ACK) |-> l.shift[7:1] == `FTMC_DEV_ADDR)
      else $error("wrong slave address acknowledged");
   chk_reg_decode: assert property (@(posedge SCL) disable iff (RST)
      (l.state == L_REG_ACK) |-> l.ptr == l.shift[2:0])
      else $error("register pointer not low three bits");
   cov_inhibit: cover property (@(posedge CORE_CLK) disable iff (RST)
      FLASH_ON && !LEVEL_RANGE_FLASH);
   cov_timeout: cover property (@(posedge CORE_CLK) disable iff (RST)
      $rose(c.timed_out));
   cov_retry: cover property (@(posedge CORE_CLK) disable iff (RST)
      c.fault == F_RETRY ##1 c.fault == F_RUN);
   cov_read: cover property (@(posedge SCL) disable iff (RST)
      l.state == L_RD_ACK);
   cov_write: cover property (@(posedge SCL) disable iff (RST)
      l.state == L_WR_ACK);
endmodule

// ### tb/ftmc_host.sv
// ======================================================
// serial master; clock stands high between frames
module ftmc_host (
   output logic scl, // serial clock, 80 ns period in frames
   output logic sda_m, // 0 pulls data low, 1 releases to pull-up
   input wire logic sda // resolved data line
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // also serves as repeated start when clock is low
   task automatic start();
      sda_m = 1'b1;
      #20 scl = 1'b1;
      #20 sda_m = 1'b0;
      #20 scl = 1'b0;
      #20;
   endtask
   task automatic stop();
      sda_m = 1'b0;
      #20 scl = 1'b1;
      #20 sda_m = 1'b1;
      #20;
   endtask
   // data set while clock low, slave bits sampled at the rise
   task automatic bit_io(input logic v, output logic s);
      sda_m = v;
      #20 scl = 1'b1;
      s = sda;
      #40 scl = 1'b0;
      #20;
   endtask
   task automatic put(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], ack);
      end
      bit_io(1'b1, ack);
   endtask
   task automatic get(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(nack, s);
   endtask
endmodule

// ### tb/ftmc_top_tb.sv
module ftmc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SHUT = 50;
   localparam int RETRY = 20;
   localparam int STEP = 10;
   logic clk, rst, en, torch_request_pin, flash_trigger_pin, fi, overvoltage_guard, opn, sht, thm, a;
   logic scl, sda_m, sda_oe_n, sda_out, standby, boost;
   logic flash_on, torch_on, rng;
   logic [3:0] code;
   wire logic sda_w;
   wire logic [7:0] st;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int i;
   // open drain: anyone pulling low wins over the pull-up
   assign sda_w = sda_oe_n ? sda_m : sda_out;
   assign st = {boost, flash_on, torch_on, rng, code};
   ftmc_top #(.SHUT_CYC(SHUT), .RETRY_CYC(RETRY), .STEP_CYC(STEP)) u_dut (
      .CORE_CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda_w),
      .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .CHIP_EN_PIN(en),
      .TORCH_REQUEST_PIN(torch_request_pin), .FLASH_TRIGGER_PIN(flash_trigger_pin),
      .FLASH_INHIBIT_PIN(fi), .OVERVOLTAGE_GUARD(overvoltage_guard),
      .OPEN_LAMP_DETECTOR(opn), .LAMP_SHORT_DETECT(sht),
      .THERMAL_TRIP(thm), .STANDBY(standby), .BOOST_EN(boost),
      .FLASH_ON(flash_on), .TORCH_ON(torch_on),
      .LEVEL_RANGE_FLASH(rng), .LEVEL_CODE(code));
   ftmc_host u_host (.scl(scl), .sda_m(sda_m), .sda(sda_w));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ======================================================
   // helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] r, v);
      logic [2:0] k;
      u_host.start();
      u_host.put(8'hB4, k[2]);
      u_host.put(r, k[1]);
      u_host.put(v, k[0]);
      u_host.stop();
      chk("write ack", 8'h00, {5'h00, k});
      cyc(8);
   endtask
   task automatic rd(input logic [7:0] r, exp);
      logic [2:0] k;
      logic [7:0] v;
      u_host.start();
      u_host.put(8'hB4, k[2]);
      u_host.put(r, k[1]);
      u_host.start();
      u_host.put(8'hB5, k[0]);
      u_host.get(1'b1, v);
      u_host.stop();
      chk("read ack", 8'h00, {5'h00, k});
      chk("read data", exp, v);
      cyc(1);
   endtask
   // fault seen: off, back on after the retry gap, off again
   task automatic retry_chk();
      cyc(6);
      chk("boost", 8'h00, {7'h00, boost});
      for (i = 0; i < 40 && boost !== 1'b1; i++) begin
         cyc(1);
      end
      chk("boost", 8'h01, {7'h00, boost});
      chk("gap", 8'h01,
         {7'h00, i >= RETRY - 10 && i <= RETRY + 10});
      cyc(6);
      chk("boost", 8'h00, {7'h00, boost});
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         num_errors++;
         $display("unexpected run length: expected %0d seen %0d",
            7999, cycles);
         report_and_stop();
      end
   end
   // ======================================================
   // tests
   initial begin
      {en, torch_request_pin, flash_trigger_pin, fi, overvoltage_guard, opn, sht, thm} = 8'h00;
      rst = 1'b1;
      cyc(10);
      rst <= 1'b0;
      cyc(3);
      chk("standby", 8'h00, {7'h00, standby});
      rd(8'h00, 8'h00);
      rd(8'h01, 8'hE0);
      rd(8'h02, 8'h00);
      wr(8'h09, 8'hE7);
      rd(8'h01, 8'hE7);
      wr(8'h05, 8'hAA);
      rd(8'h05, 8'h00);
      u_host.start();
      u_host.put(8'hB6, a);
      u_host.stop();
      chk("foreign ack", 8'h01, {7'h00, a});
      $display("test registers done");
      cyc(1);
      en <= 1'b1;
      cyc(5);
      chk("standby", 8'h01, {7'h00, standby});
      en <= 1'b0;
      cyc(SHUT - 3);
      chk("standby", 8'h01, {7'h00, standby});
      cyc(11);
      chk("standby", 8'h00, {7'h00, standby});
      wr(8'h00, 8'h08);
      chk("standby", 8'h01, {7'h00, standby});
      $display("test enable done");
      torch_request_pin <= 1'b1;
      cyc(5);
      chk("outputs", 8'hA0, st);
      torch_request_pin <= 1'b0;
      cyc(5);
      chk("outputs", 8'h00, st & 8'hE0);
      wr(8'h02, 8'h13);
      chk("outputs", 8'hA3, st);
      wr(8'h02, 8'h03);
      chk("outputs", 8'h00, st & 8'hE0);
      rd(8'h02, 8'h03);
      $display("test torch done");
      // pin flash at default timeout code, level 5
      wr(8'h01, 8'hE5);
      flash_trigger_pin <= 1'b1;
      cyc(8);
      chk("outputs", 8'hD5, st);
      fi <= 1'b1;
      cyc(5);
      chk("outputs", 8'hC3, st);
      fi <= 1'b0;
      cyc(5);
      chk("outputs", 8'hD5, st);
      cyc(8 * STEP - 22);
      chk("outputs", 8'hD5, st);
      cyc(12);
      chk("outputs", 8'h00, st & 8'hE0);
      cyc(20);
      chk("outputs", 8'h00, st & 8'hE0);
      flash_trigger_pin <= 1'b0;
      cyc(5);
      flash_trigger_pin <= 1'b1;
      cyc(8);
      chk("outputs", 8'hD5, st);
      flash_trigger_pin <= 1'b0;
      cyc(8);
      chk("outputs", 8'h00, st & 8'hE0);
      $display("test pin flash done");
      wr(8'h01, 8'hF5);
      chk("outputs", 8'hD5, st);
      fi <= 1'b1;
      cyc(5);
      chk("outputs", 8'hC3, st);
      fi <= 1'b0;
      wr(8'h01, 8'hE5);
      chk("outputs", 8'h00, st & 8'hE0);
      $display("test register flash done");
      // faults while the torch keeps the regulator on
      wr(8'h02, 8'h13);
      sht <= 1'b1;
      retry_chk();
      rd(8'h00, 8'h0C);
      sht <= 1'b0;
      cyc(40);
      chk("boost", 8'h01, {7'h00, boost});
      opn <= 1'b1;
      retry_chk();
      opn <= 1'b0;
      rd(8'h00, 8'h0E);
      thm <= 1'b1;
      cyc(5);
      rd(8'h00, 8'h0F);
      thm <= 1'b0;
      cyc(40);
      chk("boost", 8'h01, {7'h00, boost});
      overvoltage_guard <= 1'b1;
      cyc(6);
      chk("boost", 8'h00, {7'h00, boost});
      overvoltage_guard <= 1'b0;
      cyc(3 * RETRY);
      chk("boost", 8'h00, {7'h00, boost});
      // clearing the run bit with the pin long low disables the device
      wr(8'h00, 8'h00);
      chk("standby", 8'h00, {7'h00, standby});
      rd(8'h00, 8'h00);
      $display("test faults done");
      report_and_stop();
   end
endmodule
